// file: pce_event_irq.sv
// The APB slave port was chosen for this implementation.
module pce_event_irq
  import pce_pkg::*;
(
  input  wire logic        clk_sys,             // system clock, 100 MHz
  input  wire logic        rst,                 // async reset, active high
  input  wire logic        psel,                // apb select
  input  wire logic        penable,             // apb access phase
  input  wire logic        pwrite,              // apb direction
  input  wire logic [7:0]  paddr,               // apb byte address
  input  wire logic [31:0] pwdata,              // apb write data
  output logic      [31:0] prdata,              // apb read data
  output logic             pready,              // apb ready
  output logic             pslverr,             // apb error, unmapped address
  input  wire logic        pll_a_locked,        // live pll a lock
  input  wire logic        pll_b_locked,        // live pll b lock
  input  wire logic        clock_gating_done,   // live gating done
  input  wire logic        main_osc_a_ready,    // live oscillator a ready
  input  wire logic        main_osc_b_ready,    // live oscillator b ready
  input  wire logic        slow_osc_ready,      // live slow oscillator ready
  input  wire logic        core_brownout_seen,  // live core brown-out detector
  input  wire logic        io_brownout_seen,    // live io brown-out detector
  input  wire logic        clock_switch_ack,    // toggles when a clock-select is applied
  output logic      [31:0] clock_select,        // clock-select setting
  output logic             slow_osc_on,         // slow oscillator enable
  output logic             slow_osc_ext_clock,  // slow oscillator in external clock mode
  output logic             slow_osc_crystal,    // slow oscillator in crystal mode
  output logic      [2:0]  slow_osc_startup,    // slow oscillator startup select
  output logic             irq                  // level interrupt request
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] live_prev;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_prev;
    logic        switch_pending;
    logic [31:0] enable_mask;
    logic [31:0] sticky;
    logic [31:0] clock_select;
    logic        slow_on;
    logic [2:0]  slow_mode;
    logic [2:0]  slow_startup;
    logic [31:0] rdata;
  } pce_state_s;

  pce_state_s state_reg;
  pce_state_s state_next;

  logic [31:0] live_raw;
  logic [31:0] live_word;
  logic [31:0] rise;
  logic        setup_phase;
  logic        wr_access;
  logic        addr_mapped;
  logic        wr_en_set;
  logic        wr_en_clear;
  logic        wr_flag_clear;
  logic        wr_clock_select;
  logic        wr_slow_ctrl;
  logic [31:0] sticky_word;
  logic [31:0] read_word;
  logic [2:0]  mode_wr;

  // ----------------------------------------------------------------
  // live inputs gathered into the event layout
  // ----------------------------------------------------------------
  always_comb begin
    live_raw                         = RST_WORD;
    live_raw[BIT_PLL_A_LOCKED]       = pll_a_locked;
    live_raw[BIT_PLL_B_LOCKED]       = pll_b_locked;
    live_raw[BIT_CLOCK_GATING_DONE]  = clock_gating_done;
    live_raw[BIT_MAIN_OSC_A_READY]   = main_osc_a_ready;
    live_raw[BIT_MAIN_OSC_B_READY]   = main_osc_b_ready;
    live_raw[BIT_SLOW_OSC_READY]     = slow_osc_ready;
    live_raw[BIT_CORE_BROWNOUT_SEEN] = core_brownout_seen;
    live_raw[BIT_IO_BROWNOUT_SEEN]   = io_brownout_seen;
  end

  // live word seen by software: synchronised levels plus clock-ready
  always_comb begin
    live_word                        = state_reg.sync2 & EVT_EDGE_MASK;
    live_word[BIT_CLOCK_SWITCH_DONE] = ~state_reg.switch_pending;
  end

  // rising edges on synchronised live bits, each bit from its own source
  assign rise = state_reg.sync2 & ~state_reg.live_prev & EVT_EDGE_MASK;

  // clock-ready in the sticky word follows the live state directly
  always_comb begin
    sticky_word                        = state_reg.sticky & EVT_EDGE_MASK;
    sticky_word[BIT_CLOCK_SWITCH_DONE] = ~state_reg.switch_pending;
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite;

  always_comb begin
    if (paddr == OFS_CLOCK_SELECT) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFS_SLOW_OSC_CTRL) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFS_IRQ_EN_SET) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFS_IRQ_EN_CLEAR) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFS_IRQ_EN_STATE) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFS_IRQ_STICKY) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFS_IRQ_FLAG_CLEAR) begin
      addr_mapped = 1'b1;
    end else if (paddr == OFS_LIVE_STATUS) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  end

  assign wr_en_set       = wr_access & (paddr == OFS_IRQ_EN_SET);
  assign wr_en_clear     = wr_access & (paddr == OFS_IRQ_EN_CLEAR);
  assign wr_flag_clear   = wr_access & (paddr == OFS_IRQ_FLAG_CLEAR);
  assign wr_clock_select = wr_access & (paddr == OFS_CLOCK_SELECT);
  assign wr_slow_ctrl    = wr_access & (paddr == OFS_SLOW_OSC_CTRL);

  // read data is prepared in the setup cycle so prdata comes from a flop
  always_comb begin
    if (paddr == OFS_CLOCK_SELECT) begin
      read_word = state_reg.clock_select;
    end else if (paddr == OFS_SLOW_OSC_CTRL) begin
      read_word                                           = RST_WORD;
      read_word[SLOW_OSC_ON_BIT]                          = state_reg.slow_on;
      read_word[SLOW_OSC_MODE_LSB +: 3]                   = state_reg.slow_mode;
      read_word[SLOW_OSC_START_LSB +: 3]                  = state_reg.slow_startup;
    end else if (paddr == OFS_IRQ_EN_STATE) begin
      read_word = state_reg.enable_mask;
    end else if (paddr == OFS_IRQ_STICKY) begin
      read_word = sticky_word;
    end else if (paddr == OFS_LIVE_STATUS) begin
      read_word = live_word;
    end else begin
      read_word = RST_WORD;
    end
  end

  // reserved mode codes are refused; the previous mode stays
  assign mode_wr = pwdata[SLOW_OSC_MODE_LSB +: 3];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // two-stage synchronisers, then one delay for edge detection
    state_next.sync1     = live_raw;
    state_next.sync2     = state_reg.sync1;
    state_next.live_prev = state_reg.sync2;
    state_next.ack_s1    = clock_switch_ack;
    state_next.ack_s2    = state_reg.ack_s1;
    state_next.ack_prev  = state_reg.ack_s2;

    // clock-select write holds clock-ready low until the ack toggles
    if (wr_clock_select) begin
      state_next.clock_select   = pwdata;
      state_next.switch_pending = 1'b1;
    end else if (state_reg.ack_s2 != state_reg.ack_prev) begin
      state_next.switch_pending = 1'b0;
    end

    // mask: set then clear, each only on written ones
    if (wr_en_set) begin
      state_next.enable_mask = state_reg.enable_mask | (pwdata & EVT_ALL_MASK);
    end
    if (wr_en_clear) begin
      state_next.enable_mask = state_reg.enable_mask & ~pwdata;
    end

    // sticky flags: a new edge wins over a clear in the same cycle
    if (wr_flag_clear) begin
      state_next.sticky = (state_reg.sticky & ~(pwdata & EVT_EDGE_MASK)) | rise;
    end else begin
      state_next.sticky = state_reg.sticky | rise;
    end

    // slow oscillator control
    if (wr_slow_ctrl) begin
      state_next.slow_on      = pwdata[SLOW_OSC_ON_BIT];
      state_next.slow_startup = pwdata[SLOW_OSC_START_LSB +: 3];
      if (mode_wr == PCE_MODE_EXT_CLOCK || mode_wr == PCE_MODE_CRYSTAL) begin
        state_next.slow_mode = mode_wr;
      end
    end

    if (setup_phase) begin
      state_next.rdata = read_word;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata             = state_reg.rdata;
  assign pready             = 1'b1;
  assign pslverr            = psel & penable & ~addr_mapped;
  assign clock_select       = state_reg.clock_select;
  assign slow_osc_on        = state_reg.slow_on;
  assign slow_osc_ext_clock = (state_reg.slow_mode == PCE_MODE_EXT_CLOCK);
  assign slow_osc_crystal   = (state_reg.slow_mode == PCE_MODE_CRYSTAL);
  assign slow_osc_startup   = state_reg.slow_startup;
  assign irq                = |(sticky_word & state_reg.enable_mask);

endmodule

// file: pce_pkg.sv
package pce_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CLOCK_SELECT   = 8'h04;
  localparam logic [7:0] OFS_SLOW_OSC_CTRL  = 8'h30;
  localparam logic [7:0] OFS_IRQ_EN_SET     = 8'h40;
  localparam logic [7:0] OFS_IRQ_EN_CLEAR   = 8'h44;
  localparam logic [7:0] OFS_IRQ_EN_STATE   = 8'h48;
  localparam logic [7:0] OFS_IRQ_STICKY     = 8'h4C;
  localparam logic [7:0] OFS_IRQ_FLAG_CLEAR = 8'h50;
  localparam logic [7:0] OFS_LIVE_STATUS    = 8'h54;

  // ----------------------------------------------------------------
  // shared event bit layout
  // ----------------------------------------------------------------
  localparam int BIT_PLL_A_LOCKED       = 0;
  localparam int BIT_PLL_B_LOCKED       = 1;
  localparam int BIT_CLOCK_SWITCH_DONE  = 5;
  localparam int BIT_CLOCK_GATING_DONE  = 6;
  localparam int BIT_MAIN_OSC_A_READY   = 7;
  localparam int BIT_MAIN_OSC_B_READY   = 8;
  localparam int BIT_SLOW_OSC_READY     = 9;
  localparam int BIT_CORE_BROWNOUT_SEEN = 16;
  localparam int BIT_IO_BROWNOUT_SEEN   = 17;

  localparam logic [31:0] EVT_ALL_MASK  = 32'h000303E3;
  localparam logic [31:0] EVT_EDGE_MASK = 32'h000303C3;

  // ----------------------------------------------------------------
  // slow oscillator control fields
  // ----------------------------------------------------------------
  localparam int SLOW_OSC_ON_BIT    = 0;
  localparam int SLOW_OSC_MODE_LSB  = 8;
  localparam int SLOW_OSC_START_LSB = 16;

  typedef enum logic [2:0] {
    PCE_MODE_EXT_CLOCK = 3'h0,
    PCE_MODE_CRYSTAL   = 3'h1
  } pce_osc_mode_e;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD       = 32'h00000000;
  localparam logic [2:0]  RST_FIELD3     = 3'h0;

endpackage

// file: pce_event_irq_properties.sv
module pce_chk
  import pce_pkg::*;
(
  input wire logic        clk_sys,            // clock
  input wire logic        rst,                // reset
  input wire logic        psel,               // select
  input wire logic        penable,            // access
  input wire logic        pwrite,             // direction
  input wire logic [7:0]  paddr,              // address
  input wire logic [31:0] pwdata,             // write data
  input wire logic [31:0] prdata,             // read data
  input wire logic        pready,             // ready
  input wire logic        pslverr,            // error
  input wire logic [31:0] clock_select,       // clock setting
  input wire logic        slow_osc_on,        // enable
  input wire logic        slow_osc_ext_clock, // external mode
  input wire logic        slow_osc_crystal,   // crystal mode
  input wire logic        irq                 // request
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] mask_reg;
  wire acc = psel && penable;
  wire wr  = acc && pwrite;
  wire rd  = acc && !pwrite;
  wire ctl = wr && paddr == OFS_SLOW_OSC_CTRL;
  wire hit = paddr inside {OFS_CLOCK_SELECT, OFS_SLOW_OSC_CTRL, OFS_IRQ_EN_SET,
    OFS_IRQ_EN_CLEAR, OFS_IRQ_EN_STATE, OFS_IRQ_STICKY, OFS_IRQ_FLAG_CLEAR, OFS_LIVE_STATUS};
  // --------------------------------------------------
  // expected enable mask, followed from bus writes
  // --------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) mask_reg <= '0;
    else if (wr && paddr == OFS_IRQ_EN_SET) mask_reg <= mask_reg | (pwdata & EVT_ALL_MASK);
    else if (wr && paddr == OFS_IRQ_EN_CLEAR) mask_reg <= mask_reg & ~pwdata;
  end
  chk_err_unmapped: assert property (rd && !hit |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_err_mapped: assert property (acc && hit |-> !pslverr && pready)
    else $error("mapped access refused");
  chk_mask_read: assert property (rd && paddr == OFS_IRQ_EN_STATE |-> prdata == mask_reg)
    else $error("mask read wrong");
  chk_wo_zero: assert property (rd && paddr inside {8'h40, 8'h44, 8'h50} |-> prdata == 32'h0)
    else $error("write-only read not zero");
  chk_irq_masked: assert property (mask_reg == 32'h0 |-> !irq)
    else $error("irq while all masked");
  chk_osc_on: assert property (ctl |=> slow_osc_on == $past(pwdata[0]))
    else $error("enable bit not stored");
  chk_mode_ext: assert property (ctl && pwdata[10:8] == 3'h0 |=> slow_osc_ext_clock && !slow_osc_crystal)
    else $error("external mode wrong");
  chk_mode_xtal: assert property (ctl && pwdata[10:8] == 3'h1 |=> slow_osc_crystal && !slow_osc_ext_clock)
    else $error("crystal mode wrong");
  chk_mode_keep: assert property (ctl && pwdata[10:8] > 3'h1 |=> $stable(slow_osc_crystal))
    else $error("reserved mode taken");
  chk_clock_select_reg_store: assert property (wr && paddr == OFS_CLOCK_SELECT |=> clock_select == $past(pwdata))
    else $error("clock select not stored");
  cover property (wr && paddr == OFS_IRQ_EN_SET);
  cover property ($rose(irq));
  cover property (rd && !hit);
endmodule

bind pce_event_irq pce_chk u_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .clock_select, .slow_osc_on, .slow_osc_ext_clock,
  .slow_osc_crystal, .irq);

// file: testbench.sv
module testbench
  import pce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic r;} pce_row_s;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ack = 0;
  logic [7:0] paddr = '0, lv = '0;
  logic [31:0] pwdata = '0, prdata, clock_select_reg, rd, b;
  logic pready, pslverr, on, ext, xtal, irq, er;
  logic [2:0] st;
  int err_total = 0, checks = 0;
  int pos [8] = '{0, 1, 6, 7, 8, 9, 16, 17};
  logic [31:0] ow [3] = '{32'h00030101, 32'h00000500, 32'h00000000};
  logic [5:0] oe [3] = '{6'h2B, 6'h08, 6'h10};
  pce_row_s rows [14] = '{'{8'h48, 0, 0, 0, 0}, '{8'h4C, 0, 0, 32'h20, 0},
    '{8'h54, 0, 0, 32'h20, 0}, '{8'h40, 1, 32'hFFFFFFFF, 0, 0}, '{8'h48, 0, 0, 32'h303E3, 0},
    '{8'h44, 1, 32'h3, 0, 0}, '{8'h48, 0, 0, 32'h303E0, 0}, '{8'h44, 1, 0, 0, 0},
    '{8'h40, 1, 0, 0, 0}, '{8'h48, 0, 0, 32'h303E0, 0}, '{8'h50, 0, 0, 0, 0},
    '{8'h08, 0, 0, 0, 1}, '{8'h4C, 1, 32'hFFFFFFFF, 0, 0}, '{8'h4C, 0, 0, 32'h20, 0}};
  always #5 clk_sys = ~clk_sys;
  pce_event_irq dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pll_a_locked(lv[0]), .pll_b_locked(lv[1]), .clock_gating_done(lv[2]),
    .main_osc_a_ready(lv[3]), .main_osc_b_ready(lv[4]), .slow_osc_ready(lv[5]),
    .core_brownout_seen(lv[6]), .io_brownout_seen(lv[7]), .clock_switch_ack(ack),
    .clock_select(clock_select_reg), .slow_osc_on(on), .slow_osc_ext_clock(ext),
    .slow_osc_crystal(xtal), .slow_osc_startup(st), .irq);
  // --------------------------------------------------
  // bus tasks and comparison
  // --------------------------------------------------
  task automatic report_and_stop();
    $display("TB: %0d mismatches in %0d checks", err_total, checks);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t no ready within bound", $time);
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk({rd, er}, {rows[i].e, rows[i].r});
    end
    $display("TB: register table done");
    apb(OFS_IRQ_EN_CLEAR, 1'b1, 32'h20);
    foreach (pos[i]) begin
      b = 32'h1 << pos[i];
      @(posedge clk_sys) lv[i] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rdchk(OFS_LIVE_STATUS, b | 32'h20);
      @(posedge clk_sys) lv[i] <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rdchk(OFS_IRQ_STICKY, b | 32'h20);
      @(negedge clk_sys) chk(irq, (b & 32'h303C0) != 0);
      apb(OFS_IRQ_FLAG_CLEAR, 1'b1, b | 32'h20);
      rdchk(OFS_IRQ_STICKY, 32'h20);
      @(negedge clk_sys) chk(irq, 0);
    end
    $display("TB: event flags done");
    apb(OFS_CLOCK_SELECT, 1'b1, 32'hA5);
    @(negedge clk_sys) chk(clock_select_reg, 32'hA5);
    rdchk(OFS_LIVE_STATUS, 32'h0);
    @(posedge clk_sys) ack <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdchk(OFS_LIVE_STATUS, 32'h20);
    foreach (ow[i]) begin
      apb(OFS_SLOW_OSC_CTRL, 1'b1, ow[i]);
      @(negedge clk_sys) chk({on, ext, xtal, st}, oe[i]);
    end
    $display("TB: clock and oscillator done");
    @(posedge clk_sys) rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(OFS_IRQ_EN_STATE, 32'h0);
    chk(clock_select_reg, 32'h0);
    $display("TB: second reset done");
    report_and_stop();
  end
endmodule
